// ===== rtl/lpm_mode_ctrl.sv
// Functional notes
// RQ1 - Four mode bits in the status word select active or sleep levels zero to four.
// RQ2 - All mode bits clear: processor runs, all enabled clocks run.
// RQ3 - Halt bit only: processor and main clock stop, subsystem and auxiliary run.
// RQ4 - Halt plus dc-generator-off: oscillator and generator stop unless feeding subsystem clock.
// RQ5 - Halt plus subsystem-off: subsystem clock and oscillator stop, generator stays on.
// RQ6 - Halt and both generator bits: only the auxiliary clock keeps running; it also stops here when the oscillator feeds it.
// RQ7 - All four bits set: processor and every clock source stop.
// RQ8 - A written mode takes effect at once, with no further event.
// RQ9 - Peripherals on a gated clock stay inactive until that clock runs again.
// RQ10 - Sleep never alters pins, memory or register contents.
// RQ11 - Any enabled interrupt request wakes the device from sleep.
// RQ12 - Interrupt entry saves instruction pointer and status word with mode bits.
// RQ13 - Entry clears halt, subsystem-off and crystal-off bits, not dc-generator-off.
// RQ14 - Interrupt return restores the stacked status word and its mode.
// RQ15 - A stacked word altered in the service routine selects the mode on return.
// RQ16 - Mode bits and stacked word are readable and writable by any access.
// RQ17 - Clock gating never produces shortened or glitched clock pulses.
`timescale 1ns/1ps
`default_nettype none

module lpm_mode_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic irq_request,
    input wire logic nmi_request,
    input wire logic interrupt_return,
    input wire logic [15:0] instruction_pointer,
    output logic irq_accept,
    output logic [15:0] resume_pointer,
    output logic processor_run,
    output logic main_clk_tick,
    output logic sub_clk_tick,
    output logic aux_clk_tick,
    output logic sub_domain_active,
    output logic aux_domain_active,
    output logic tunable_oscillator_en,
    output logic dc_generator_en,
    output logic crystal_en
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] status_word;
    logic [15:0] stacked_status;
    logic [15:0] stacked_pointer;
    logic [2:0] clock_source;
    logic bus_grant;
    logic [31:0] next_readdata;
    logic bus_wr;
    logic take_irq;
    lpm_pkg::lpm_mode_t mode;

    logic processor_halt_bit;
    logic crystal_off_bit;
    logic dc_generator_off_bit;
    logic subsystem_clock_off_bit;
    logic global_irq_enable;

    logic next_main_run;
    logic next_sub_run;
    logic next_aux_run;
    logic next_osc_en;
    logic next_dc_en;
    logic next_crystal_en;
    logic main_active;

    assign processor_halt_bit = status_word[lpm_pkg::BIT_PROCESSOR_HALT];
    assign crystal_off_bit = status_word[lpm_pkg::BIT_CRYSTAL_OFF];
    assign dc_generator_off_bit = status_word[lpm_pkg::BIT_DC_GENERATOR_OFF];
    assign subsystem_clock_off_bit = status_word[lpm_pkg::BIT_SUBSYSTEM_CLOCK_OFF];
    assign global_irq_enable = status_word[lpm_pkg::BIT_GLOBAL_IRQ_ENABLE];

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the answer
    // ------------------------------------------------------------------
    // The request is held by the master; waitrequest drops for exactly one
    // cycle and the access completes at that edge.
    assign bus_wr = avs_write && !avs_waitrequest;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_grant <= 1'b0;
        end else begin
            bus_grant <= (avs_read || avs_write) && !bus_grant;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !bus_grant);
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            lpm_pkg::OFS_STATUS_WORD: begin
                next_readdata[15:0] = status_word; // RQ16
            end
            lpm_pkg::OFS_STACKED_STATUS: begin
                next_readdata[15:0] = stacked_status; // RQ16
            end
            lpm_pkg::OFS_STACKED_POINTER: begin
                next_readdata[15:0] = stacked_pointer;
            end
            lpm_pkg::OFS_CLOCK_SOURCE: begin
                next_readdata[2:0] = clock_source;
            end
            lpm_pkg::OFS_CLOCK_STATE: begin
                next_readdata[lpm_pkg::ST_PROCESSOR] = processor_run;
                next_readdata[lpm_pkg::ST_MAIN] = main_active;
                next_readdata[lpm_pkg::ST_SUB] = sub_domain_active;
                next_readdata[lpm_pkg::ST_AUX] = aux_domain_active;
                next_readdata[lpm_pkg::ST_OSC] = tunable_oscillator_en;
                next_readdata[lpm_pkg::ST_DC_GEN] = dc_generator_en;
                next_readdata[lpm_pkg::ST_CRYSTAL] = crystal_en;
                next_readdata[lpm_pkg::ST_MODE_LSB +: 3] = mode;
            end
            default: begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !bus_grant) begin
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt entry and return
    // ------------------------------------------------------------------
    // Non-maskable requests wake regardless of the global enable. A single
    // stack slot is kept, so nested entries overwrite the saved frame.
    assign take_irq = (nmi_request || (irq_request && global_irq_enable)) && !irq_accept; // RQ11

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_accept <= 1'b0;
        end else begin
            irq_accept <= take_irq;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_word <= lpm_pkg::STATUS_WORD_RESET;
        end else if (take_irq) begin
            status_word <= status_word & ~lpm_pkg::ENTRY_CLEAR_MASK; // RQ13 RQ11
        end else if (interrupt_return) begin
            status_word <= stacked_status; // RQ14 RQ15
        end else if (bus_wr && avs_address == lpm_pkg::OFS_STATUS_WORD) begin
            status_word <= avs_writedata[15:0] & lpm_pkg::STATUS_WORD_MASK; // RQ8 RQ16 RQ1
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stacked_status <= lpm_pkg::STATUS_WORD_RESET;
        end else if (take_irq) begin
            stacked_status <= status_word; // RQ12
        end else if (bus_wr && avs_address == lpm_pkg::OFS_STACKED_STATUS) begin
            stacked_status <= avs_writedata[15:0] & lpm_pkg::STATUS_WORD_MASK; // RQ15 RQ16
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stacked_pointer <= 16'h0000;
        end else if (take_irq) begin
            stacked_pointer <= instruction_pointer; // RQ12
        end else if (bus_wr && avs_address == lpm_pkg::OFS_STACKED_POINTER) begin
            stacked_pointer <= avs_writedata[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resume_pointer <= 16'h0000;
        end else begin
            resume_pointer <= stacked_pointer;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_source <= lpm_pkg::CLOCK_SOURCE_RESET;
        end else if (bus_wr && avs_address == lpm_pkg::OFS_CLOCK_SOURCE) begin
            clock_source <= avs_writedata[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Mode decode and clock source control
    // ------------------------------------------------------------------
    // Only clocks are gated; no state anywhere is reset by a mode change.
    always_comb begin
        case ({subsystem_clock_off_bit, dc_generator_off_bit, crystal_off_bit,
               processor_halt_bit})
            4'b0000: mode = lpm_pkg::LPM_ACTIVE; // RQ1
            4'b0001: mode = lpm_pkg::LPM_SLEEP_LEVEL_ZERO;
            4'b0101: mode = lpm_pkg::LPM_SLEEP_LEVEL_ONE;
            4'b1001: mode = lpm_pkg::LPM_SLEEP_LEVEL_TWO;
            4'b1101: mode = lpm_pkg::LPM_SLEEP_LEVEL_THREE;
            4'b1111: mode = lpm_pkg::LPM_SLEEP_LEVEL_FOUR;
            default: mode = lpm_pkg::LPM_OTHER;
        endcase
    end

    always_comb begin
        next_main_run = !processor_halt_bit; // RQ2 RQ3
        next_sub_run = !subsystem_clock_off_bit; // RQ5
        next_osc_en = !subsystem_clock_off_bit
            && !(dc_generator_off_bit && !clock_source[lpm_pkg::BIT_OSC_FEEDS_SUB]); // RQ4 RQ5
        next_dc_en = !(dc_generator_off_bit
            && !(next_osc_en && clock_source[lpm_pkg::BIT_OSC_FEEDS_SUB])); // RQ4 RQ6
        next_crystal_en = !(crystal_off_bit
            && !(next_sub_run && clock_source[lpm_pkg::BIT_CRYSTAL_FEEDS_SUB])); // RQ7
        if (!processor_halt_bit) begin
            next_osc_en = 1'b1; // RQ2
            next_dc_en = 1'b1;
        end
        next_aux_run = clock_source[lpm_pkg::BIT_OSC_FEEDS_AUX] ? next_osc_en
            : next_crystal_en; // RQ6 RQ7
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            processor_run <= 1'b1;
        end else begin
            processor_run <= next_main_run; // RQ8 RQ10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tunable_oscillator_en <= 1'b1;
        end else begin
            tunable_oscillator_en <= next_osc_en; // RQ8
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dc_generator_en <= 1'b1;
        end else begin
            dc_generator_en <= next_dc_en; // RQ4 RQ6
        end
    end

    // A crystal that feeds a running subsystem domain is kept on, so that
    // domain never loses its source while the off bit is set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crystal_en <= 1'b1;
        end else begin
            crystal_en <= next_crystal_en; // RQ7
        end
    end

    // ------------------------------------------------------------------
    // Gated clock ticks for the processor and peripheral domains
    // ------------------------------------------------------------------
    // Peripherals advance only on their tick, so a stopped domain is held
    // inactive until its tick returns.
    lpm_tick_gate #(.DIV(lpm_pkg::DIV_MAIN)) u_main_gate (
        .clk(clk),
        .rst_n(rst_n),
        .run(next_main_run),
        .tick(main_clk_tick),
        .active(main_active)
    ); // RQ17

    lpm_tick_gate #(.DIV(lpm_pkg::DIV_SUB)) u_sub_gate (
        .clk(clk),
        .rst_n(rst_n),
        .run(next_sub_run && next_osc_en),
        .tick(sub_clk_tick),
        .active(sub_domain_active)
    ); // RQ9

    lpm_tick_gate #(.DIV(lpm_pkg::DIV_AUX)) u_aux_gate (
        .clk(clk),
        .rst_n(rst_n),
        .run(next_aux_run),
        .tick(aux_clk_tick),
        .active(aux_domain_active)
    ); // RQ9

endmodule

`default_nettype wire

// ===== rtl/lpm_pkg.sv
package lpm_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the Avalon-MM slave
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_STATUS_WORD = 5'h00;
    localparam logic [4:0] OFS_STACKED_STATUS = 5'h04;
    localparam logic [4:0] OFS_STACKED_POINTER = 5'h08;
    localparam logic [4:0] OFS_CLOCK_SOURCE = 5'h0C;
    localparam logic [4:0] OFS_CLOCK_STATE = 5'h10;

    // ------------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------------
    localparam int SW_W = 16;
    localparam int BIT_GLOBAL_IRQ_ENABLE = 3;
    localparam int BIT_PROCESSOR_HALT = 4;
    localparam int BIT_CRYSTAL_OFF = 5;
    localparam int BIT_DC_GENERATOR_OFF = 6;
    localparam int BIT_SUBSYSTEM_CLOCK_OFF = 7;
    localparam logic [15:0] STATUS_WORD_RESET = 16'h0000;
    localparam logic [15:0] STATUS_WORD_MASK = 16'h01FF;
    localparam logic [15:0] ENTRY_CLEAR_MASK = 16'h00B8;

    // ------------------------------------------------------------------
    // Clock source selection and clock state fields
    // ------------------------------------------------------------------
    localparam int BIT_OSC_FEEDS_SUB = 0;
    localparam int BIT_CRYSTAL_FEEDS_SUB = 1;
    localparam int BIT_OSC_FEEDS_AUX = 2;
    localparam logic [2:0] CLOCK_SOURCE_RESET = 3'h0;
    localparam int ST_PROCESSOR = 0;
    localparam int ST_MAIN = 1;
    localparam int ST_SUB = 2;
    localparam int ST_AUX = 3;
    localparam int ST_OSC = 4;
    localparam int ST_DC_GEN = 5;
    localparam int ST_CRYSTAL = 6;
    localparam int ST_MODE_LSB = 8;

    // ------------------------------------------------------------------
    // Tick dividers per clock domain
    // ------------------------------------------------------------------
    localparam int DIV_MAIN = 1;
    localparam int DIV_SUB = 2;
    localparam int DIV_AUX = 4;

    typedef enum logic [2:0] {
        LPM_ACTIVE = 3'b000,
        LPM_SLEEP_LEVEL_ZERO = 3'b001,
        LPM_SLEEP_LEVEL_ONE = 3'b010,
        LPM_SLEEP_LEVEL_TWO = 3'b011,
        LPM_SLEEP_LEVEL_THREE = 3'b100,
        LPM_SLEEP_LEVEL_FOUR = 3'b101,
        LPM_OTHER = 3'b110
    } lpm_mode_t;

endpackage

// ===== rtl/lpm_tick_gate.sv
`timescale 1ns/1ps
`default_nettype none

module lpm_tick_gate #(
    parameter int DIV = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic tick,
    output logic active
);

    // ------------------------------------------------------------------
    // Gated tick generator
    // ------------------------------------------------------------------
    // A period that has started is always finished, so a stop request never
    // shortens the last pulse and a start always begins a full period.
    logic [7:0] count;
    logic period_end;

    assign period_end = (count == 8'(DIV - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else if (!active || period_end) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
        end else if (!active) begin
            active <= run;
        end else if (period_end) begin
            active <= run; // RQ17
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= active && period_end;
        end
    end

endmodule

`default_nettype wire

// ===== test/lpm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] cmd,
    input wire logic irq_accept,
    input wire logic processor_run,
    output logic irq_request,
    output logic nmi_request,
    output logic interrupt_return,
    output logic [15:0] instruction_pointer
);
    // A request stays pending until any request is accepted; dropping it on accept avoids re-entry.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_request <= 1'b0;
            nmi_request <= 1'b0;
            interrupt_return <= 1'b0;
        end else begin
            irq_request <= cmd[0] | (irq_request & !irq_accept);
            nmi_request <= cmd[1] | (nmi_request & !irq_accept);
            interrupt_return <= cmd[2];
        end
    end
    // The pointer only advances while the processor runs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instruction_pointer <= 16'h1000;
        end else if (processor_run) begin
            instruction_pointer <= instruction_pointer + 16'h0002;
        end
    end
endmodule
`default_nettype wire

// ===== test/lpm_mode_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_mode_ctrl_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic irq_request,
    input wire logic nmi_request,
    input wire logic interrupt_return,
    input wire logic [15:0] instruction_pointer,
    input wire logic irq_accept,
    input wire logic [15:0] resume_pointer,
    input wire logic processor_run,
    input wire logic main_clk_tick,
    input wire logic sub_clk_tick,
    input wire logic aux_clk_tick,
    input wire logic sub_domain_active,
    input wire logic tunable_oscillator_en,
    input wire logic dc_generator_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");
    property p_write_mode;
        avs_write && !avs_waitrequest && avs_address == lpm_pkg::OFS_STATUS_WORD
            && !irq_request && !nmi_request && !interrupt_return
            |-> ##2 processor_run == !$past(avs_writedata[lpm_pkg::BIT_PROCESSOR_HALT], 2);
    endproperty
    a_write_mode: assert property (p_write_mode)
        else $error("written halt bit not applied at once");
    property p_main_stop;
        !processor_run [*3] |-> !main_clk_tick;
    endproperty
    a_main_stop: assert property (p_main_stop)
        else $error("main tick while processor halted");
    property p_sub_gap;
        sub_clk_tick |=> !sub_clk_tick;
    endproperty
    a_sub_gap: assert property (p_sub_gap)
        else $error("subsystem tick period shortened");
    property p_aux_gap;
        aux_clk_tick |=> !aux_clk_tick [*3];
    endproperty
    a_aux_gap: assert property (p_aux_gap)
        else $error("auxiliary tick period shortened");
    property p_sub_idle;
        !sub_domain_active [*2] |-> !sub_clk_tick;
    endproperty
    a_sub_idle: assert property (p_sub_idle)
        else $error("subsystem tick while domain inactive");
    property p_irq_pulse;
        irq_accept |=> !irq_accept;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("accept pulse longer than one cycle");
    property p_nmi_taken;
        nmi_request && !irq_accept |=> irq_accept;
    endproperty
    a_nmi_taken: assert property (p_nmi_taken)
        else $error("non-maskable request not taken");
    property p_wake;
        irq_accept |=> processor_run;
    endproperty
    a_wake: assert property (p_wake)
        else $error("processor not woken after entry");
    property p_ptr;
        irq_accept |=> resume_pointer == $past(instruction_pointer, 2);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("stacked pointer differs from pointer at entry");
    property p_osc_on;
        processor_run |-> tunable_oscillator_en && dc_generator_en;
    endproperty
    a_osc_on: assert property (p_osc_on)
        else $error("oscillator off while processor runs");
    c_accept: cover property (irq_accept);
    c_halt: cover property (!processor_run [*3]);
    c_return: cover property (interrupt_return);
endmodule
bind lpm_mode_ctrl lpm_mode_ctrl_sva u_lpm_mode_ctrl_sva (.*);
`default_nettype wire

// ===== test/lpm_mode_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_mode_ctrl_test;
    logic clk, rst_n, avs_read, avs_write, irq_request, nmi_request, interrupt_return;
    logic irq_accept, processor_run, main_clk_tick, sub_clk_tick, aux_clk_tick;
    logic sub_domain_active, aux_domain_active, tunable_oscillator_en, dc_generator_en;
    logic crystal_en, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] instruction_pointer, resume_pointer, ipx;
    logic [2:0] cmd;
    int miscompares, total_checks;
    lpm_mode_ctrl u_lpm_mode_ctrl (.*);
    lpm_core_model u_lpm_core_model (.*);
    // ----------------------------------------
    // Clock, then compare, bus, core command, accept wait and closing tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check(n < 50, 1);
    endtask
    task automatic core(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 3'h0;
    endtask
    task automatic wait_accept;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq_accept !== 1'b1 && n < 20);
        check(n < 20, 1);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_modes;
        logic [15:0] sw [8] = '{16'h0, 16'h10, 16'h50, 16'h90, 16'hD0, 16'hF0, 16'h50, 16'h20};
        logic [5:0] ex [8] = '{6'h3F, 6'h3E, 6'h30, 6'h34, 6'h30, 6'h00, 6'h3E, 6'h1F};
        for (int i = 0; i < 8; i++) begin
            bus(1, lpm_pkg::OFS_CLOCK_SOURCE, {29'h0, i == 7, 1'b0, i == 6});
            bus(1, lpm_pkg::OFS_STATUS_WORD, {16'h0, sw[i]});
            repeat (10) @(posedge clk);
            check({crystal_en, aux_domain_active, sub_domain_active, dc_generator_en,
                tunable_oscillator_en, processor_run}, ex[i]);
            check(main_clk_tick, !sw[i][lpm_pkg::BIT_PROCESSOR_HALT]);
            bus(0, lpm_pkg::OFS_CLOCK_STATE, 0);
            check(rd[10:8], (i == 6) ? 2 : (i == 7) ? 6 : i);
            bus(0, lpm_pkg::OFS_STATUS_WORD, 0);
            check(rd, {16'h0, sw[i]});
        end
        bus(1, lpm_pkg::OFS_CLOCK_SOURCE, 0);
        bus(1, lpm_pkg::OFS_STATUS_WORD, 0);
        $display("done t_modes");
    endtask
    task automatic t_irq_wake;
        bus(1, lpm_pkg::OFS_STATUS_WORD, 32'h000000D8);
        repeat (4) @(posedge clk);
        ipx = instruction_pointer;
        core(3'h1);
        wait_accept;
        bus(0, lpm_pkg::OFS_STATUS_WORD, 0);
        check(rd, 32'h00000040);
        check(processor_run, 1);
        bus(0, lpm_pkg::OFS_STACKED_STATUS, 0);
        check(rd, 32'h000000D8);
        bus(0, lpm_pkg::OFS_STACKED_POINTER, 0);
        check(rd, {16'h0, ipx});
        check(resume_pointer, ipx);
        core(3'h4);
        repeat (3) @(posedge clk);
        bus(0, lpm_pkg::OFS_STATUS_WORD, 0);
        check(rd, 32'h000000D8);
        check(processor_run, 0);
        $display("done t_irq_wake");
    endtask
    task automatic t_mask;
        bus(1, lpm_pkg::OFS_STATUS_WORD, 32'h00000010);
        core(3'h1);
        repeat (10) @(posedge clk);
        bus(0, lpm_pkg::OFS_STATUS_WORD, 0);
        check(rd, 32'h00000010);
        core(3'h2);
        wait_accept;
        repeat (2) @(posedge clk);
        check(processor_run, 1);
        $display("done t_mask");
    endtask
    task automatic t_modify;
        bus(1, lpm_pkg::OFS_STACKED_STATUS, 32'h00000000);
        core(3'h4);
        repeat (3) @(posedge clk);
        bus(0, lpm_pkg::OFS_STATUS_WORD, 0);
        check(rd, 32'h00000000);
        check(processor_run, 1);
        $display("done t_modify");
    endtask
    task automatic t_unmapped;
        bus(1, 5'h14, 32'hFFFFFFFF);
        bus(0, 5'h14, 0);
        check(rd, 32'h00000000);
        bus(1, lpm_pkg::OFS_STATUS_WORD, 32'hFFFF0E07);
        bus(0, lpm_pkg::OFS_STATUS_WORD, 0);
        check(rd, 32'h00000007);
        $display("done t_unmapped");
    endtask
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        cmd = 3'h0;
        miscompares = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, lpm_pkg::OFS_STATUS_WORD, 0);
        check(rd, 32'h0);
        t_modes;
        t_irq_wake;
        t_mask;
        t_modify;
        t_unmapped;
        end_of_test;
    end
    // Generous bound: the scenarios need well under a thousand cycles.
    initial begin
        #1000000;
        miscompares++;
        end_of_test;
    end
endmodule
`default_nettype wire
